/* File: include/pci_latency_aperture_cfg_defines.vh */
// constants for the latency timer and graphics window configuration bank
// assumes byte offsets on an 8-bit configuration address, dword lanes
`ifndef PCI_LATENCY_APERTURE_CFG_DEFINES_VH
`define PCI_LATENCY_APERTURE_CFG_DEFINES_VH
`define LAT_TIMER_OFS     8'h0D
`define HDR_TYPE_OFS      8'h0E
`define WIN_BASE_OFS      8'h10
`define LAT_TIMER_RST     8'h00
`define HDR_TYPE_VAL      8'h00
`define WIN_UPPER_RST     4'h0
`define WIN_LOWER_RST     6'h00
`define WIN_LOW_CONST     22'h000008
`define LAT_KEEP_MASK     8'hF8
`define WIN_UPPER_MSB     31
`define WIN_UPPER_LSB     28
`define WIN_LOWER_MSB     27
`define WIN_LOWER_LSB     22
`define WIN_LOWER_BITS    6
`endif

/* File: design/pci_latency_aperture_cfg.v */
// latency timer, header layout type and graphics window base registers
// assumes a single-cycle configuration read/write port on ref_clk and
// initiator handshake inputs sampled on the same clock as the pci clock;
// the size select level comes from a register kept elsewhere
`timescale 1ns/10ps
`include "pci_latency_aperture_cfg_defines.vh"

module pci_latency_aperture_cfg (
    // clock and synchronous reset
    input  wire        ref_clk,
    input  wire        rst_n,

    // configuration port, one strobe per access
    input  wire        cfg_wr,
    input  wire        cfg_rd,
    input  wire [7:0]  cfg_addr,
    input  wire [3:0]  cfg_be,
    input  wire [31:0] cfg_wdata,

    // size select level, bit n gates base bit 22+n
    input  wire [5:0]  graphics_window_size_select,

    // own initiator tenure as seen by the bus interface
    input  wire        init_start,
    input  wire        init_busy,
    input  wire        bus_grant_n,
    input  wire        data_phase_done,

    // read answer, data held until the next read
    output reg  [31:0] cfg_rdata_r,
    output reg         cfg_rvalid_r,

    // visible base for the window address compare
    output reg  [31:0] window_base_r,

    // tenure status toward the bus interface
    output reg  [7:0]  latency_count_r,
    output reg         slice_expired_r,
    output reg         final_phase_r,
    output reg         release_bus_r
);

    // register map, dword aligned
    //   0x0C lane 1 : initiator latency timer, read/write
    //   0x0C lane 2 : header layout type, reads zero, no storage
    //   0x10        : graphics window base
    //                 31:28 storage, 27:22 storage behind the select,
    //                 21:0 constant with bit 3 set
    //   0x0D and 0x0E are byte addresses inside dword 0x0C
    // other dwords and lanes read zero and ignore writes

    // state of the tenure tracker, one-hot
    localparam [2:0] ST_IDLE  = 3'b001;
    localparam [2:0] ST_BURST = 3'b010;
    localparam [2:0] ST_LAST  = 3'b100;

    // software-visible storage
    reg  [7:0]  initiator_latency_timer_r;
    reg  [3:0]  win_upper_r;
    reg  [5:0]  win_lower_r;

    // tenure tracker and next values
    reg  [2:0]  state_r;
    reg  [2:0]  state_nxt;
    reg  [7:0]  count_nxt;
    reg  [31:0] rdata_nxt;

    // decode terms
    wire [7:0]  lat_ofs;
    wire [7:0]  win_ofs;
    wire        hit_lat;
    wire        hit_win;
    wire [3:0]  lat_wr_lane;
    wire [3:0]  win_wr_lane;

    // window and count terms
    wire [7:0]  lat_load;
    wire [5:0]  win_lower_vis;
    wire [31:0] win_base_vis;
    wire        lat_enabled;
    wire        count_zero;
    wire        slice_over;
    wire        grant_gone;
    wire        tenure_live;
    wire        load_now;
    wire        step_now;

    // offsets held at full width so the dword part can be sliced
    assign lat_ofs = `LAT_TIMER_OFS;
    assign win_ofs = `WIN_BASE_OFS;

    // byte 0x0D sits in lane 1 of dword 0x0C; 0x0E shares that dword
    assign hit_lat = (cfg_addr[7:2] == lat_ofs[7:2]);
    assign hit_win = (cfg_addr[7:2] == win_ofs[7:2]);

    // per-lane write strobes; lane 2 of dword 0x0C has nothing behind
    // it, so header layout type writes fall away here
    assign lat_wr_lane = cfg_be & {4{cfg_wr && hit_lat}};
    assign win_wr_lane = cfg_be & {4{cfg_wr && hit_win}};

    // low three timer bits never reach the count
    assign lat_load    = initiator_latency_timer_r & `LAT_KEEP_MASK;
    assign lat_enabled = (lat_load != 8'h00);
    assign count_zero  = (latency_count_r == 8'h00);

    // the bank counts on ref_clk, which stands in for the pci clock;
    // a faster clock shortens the slice in time, not in cycles
    assign slice_over  = lat_enabled && count_zero;
    assign grant_gone  = bus_grant_n;
    assign tenure_live = init_busy;
    assign load_now    = init_start && (state_r == ST_IDLE);
    assign step_now    = (state_r != ST_IDLE) && !count_zero;

    // size map of the select; each clear bit hides one more base bit
    //   bit n of the select gates base bit 22+n
    //   6'b111111 -> 4 MB window
    //   6'b111110 -> 8 MB
    //   6'b111100 -> 16 MB
    //   6'b111000 -> 32 MB
    //   6'b110000 -> 64 MB
    //   6'b100000 -> 128 MB
    //   6'b000000 -> 256 MB
    // other patterns leave holes in the decode; software keeps to these

    // masked lower bits read zero where the size select is clear
    assign win_lower_vis = win_lower_r & graphics_window_size_select;
    assign win_base_vis  = {win_upper_r, win_lower_vis,
                            `WIN_LOW_CONST};

    // latency timer storage, full 8 bits kept for read-back;
    // only the count path drops bits 2:0
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            initiator_latency_timer_r <= `LAT_TIMER_RST;
        end else if (lat_wr_lane[1]) begin
            // a write with lane 1 clear leaves the timer as it was
            initiator_latency_timer_r <= cfg_wdata[15:8];
        end
    end

    // upper window bits are plain storage
    // lane 3 carries bits 31:24; 27:24 belong to the gated loop below
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            win_upper_r <= `WIN_UPPER_RST;
        end else if (win_wr_lane[3]) begin
            win_upper_r <= cfg_wdata[`WIN_UPPER_MSB:`WIN_UPPER_LSB];
        end
    end

    // one flop per lower bit; a write lands only if the bit is writable.
    // a bit whose select is clear keeps its old value behind the mask,
    // so software must rewrite it after opening it up
    genvar gi;
    generate
        for (gi = 0; gi < `WIN_LOWER_BITS; gi = gi + 1) begin : g_lower
            // which byte lane carries this bit
            localparam integer BIT = `WIN_LOWER_LSB + gi;
            localparam integer LANE = BIT / 8;
            always @(posedge ref_clk) begin
                if (!rst_n) begin
                    win_lower_r[gi] <= 1'b0;
                end else if (win_wr_lane[LANE] &&
                             graphics_window_size_select[gi]) begin
                    win_lower_r[gi] <= cfg_wdata[BIT];
                end
            end
        end
    endgenerate

    // read decode; header layout type is a constant, no flop behind it.
    // unmapped dwords and reserved lanes read zero
    always @* begin
        rdata_nxt = 32'h0000_0000;
        if (hit_lat) begin
            // lane 1: timer, lane 2: header layout type
            rdata_nxt[15:8]  = initiator_latency_timer_r;
            rdata_nxt[23:16] = `HDR_TYPE_VAL;
        end else if (hit_win) begin
            rdata_nxt = win_base_vis;
        end
    end

    // registered read answer, one cycle after the strobe;
    // data stands until the next read so a slow master can still take it
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            cfg_rdata_r  <= 32'h0000_0000;
            cfg_rvalid_r <= 1'b0;
        end else begin
            cfg_rvalid_r <= cfg_rd;
            if (cfg_rd) begin
                cfg_rdata_r <= rdata_nxt;
            end
        end
    end

    // base seen by the address decoder, registered for timing;
    // it trails a config write by one cycle, and its reset value
    // carries the constant bit 3 like the read path does
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            window_base_r <= {`WIN_UPPER_RST, `WIN_LOWER_RST,
                              `WIN_LOW_CONST};
        end else begin
            window_base_r <= win_base_vis;
        end
    end

    // tenure tracker
    //   idle  : waiting for an initiator transaction to begin
    //   burst : own tenure running, slice counting down
    //   last  : slice gone and grant withdrawn; the phase in flight
    //           is the final one, then the bus is given up
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (init_start) begin
                    state_nxt = ST_BURST;
                end
            end
            ST_BURST: begin
                if (!tenure_live) begin
                    // tenure ended on its own
                    state_nxt = ST_IDLE;
                end else if (slice_over && grant_gone) begin
                    // forced off only by an enabled slice
                    state_nxt = ST_LAST;
                end
            end
            ST_LAST: begin
                // only the phase in progress completes
                if (data_phase_done || !tenure_live) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                // an illegal code falls back to idle
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // counter: load at start, count down once per clock, stop at zero;
    // it parks at zero rather than wrapping so expiry stays asserted.
    // with a timer of 0x08: start taken at edge 0, count 8 after it,
    // zero after edge 8 with expiry, final phase from edge 9 when the
    // grant is already gone, release one edge after the phase ends
    always @* begin
        count_nxt = latency_count_r;
        if (load_now) begin
            count_nxt = lat_load;
        end else if (step_now) begin
            count_nxt = latency_count_r - 8'h01;
        end
    end

    // tenure state and counter flops
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            state_r         <= ST_IDLE;
            latency_count_r <= 8'h00;
        end else begin
            state_r         <= state_nxt;
            latency_count_r <= count_nxt;
        end
    end

    // expiry flag; a zero timer never expires so never forces release.
    // outputs are all flops so the bus side sees no decode glitches
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            slice_expired_r <= 1'b0;
        end else begin
            slice_expired_r <= lat_enabled && (state_nxt != ST_IDLE) &&
                               (count_nxt == 8'h00);
        end
    end

    // final phase marker, up for as long as the last state lasts
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            final_phase_r <= 1'b0;
        end else begin
            final_phase_r <= (state_nxt == ST_LAST);
        end
    end

    // release pulse on the way out of the last state only; a tenure that
    // ends on its own before expiry needs no forced release
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            release_bus_r <= 1'b0;
        end else begin
            release_bus_r <= (state_r == ST_LAST) &&
                             (state_nxt == ST_IDLE);
        end
    end

endmodule

/* File: verification/cfg_bank_asserts.sv */
// port checker for the latency timer and graphics window bank
// bound to the bank from the bench top; sees only its ports
`timescale 1ns/10ps
`include "pci_latency_aperture_cfg_defines.vh"
module cfg_bank_asserts (
    input wire        ref_clk, rst_n, cfg_wr, cfg_rd, init_start,
    input wire        init_busy, bus_grant_n, data_phase_done,
    input wire [7:0]  cfg_addr,
    input wire [3:0]  cfg_be,
    input wire [31:0] cfg_wdata, cfg_rdata_r, window_base_r,
    input wire [5:0]  graphics_window_size_select,
    input wire        cfg_rvalid_r, slice_expired_r, final_phase_r,
    input wire        release_bus_r,
    input wire [7:0]  latency_count_r
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    property p_rv; cfg_rd |=> cfg_rvalid_r; endproperty
    a_rv: assert property (p_rv) else $error("no read answer");
    property p_hdr; cfg_rd && cfg_addr[7:2] == 6'h03
        |=> cfg_rdata_r[23:16] == 8'h00; endproperty
    a_hdr: assert property (p_hdr) else $error("header not zero");
    property p_up; cfg_wr && cfg_addr[7:2] == 6'h04 && cfg_be[3]
        |=> ##1 window_base_r[31:28] == $past(cfg_wdata[31:28], 2);
    endproperty
    a_up: assert property (p_up) else $error("upper base lost");
    // with a steady select, gated base bits must read zero
    property p_gate; $stable(graphics_window_size_select) |->
        (window_base_r[27:22] & ~graphics_window_size_select) == 6'h00;
    endproperty
    a_gate: assert property (p_gate) else $error("gated bit set");
    property p_low; window_base_r[21:0] == `WIN_LOW_CONST; endproperty
    a_low: assert property (p_low) else $error("low base bits");
    property p_dec; init_busy && !init_start && latency_count_r != 8'h00
        |=> latency_count_r == $past(latency_count_r) - 8'h01; endproperty
    a_dec: assert property (p_dec) else $error("count step");
    property p_exp; $rose(slice_expired_r)
        |-> latency_count_r == 8'h00 && init_busy; endproperty
    a_exp: assert property (p_exp) else $error("early expiry");
    property p_fin; slice_expired_r && bus_grant_n && init_busy &&
        !final_phase_r && !data_phase_done && !release_bus_r
        |=> final_phase_r; endproperty
    a_fin: assert property (p_fin) else $error("no final phase");
    property p_rel; final_phase_r && data_phase_done
        |=> release_bus_r && !final_phase_r ##1 !release_bus_r; endproperty
    a_rel: assert property (p_rel) else $error("no release");
endmodule

/* File: verification/pci_arbiter_model.sv */
// arbiter and initiator-side model facing the bank
// drives by non-blocking assignment on the rising edge
`timescale 1ns/10ps
module pci_arbiter_model (
    input  wire ref_clk, rst_n, init_start, final_phase_r, release_bus_r,
    input  wire revoke,
    output reg  init_busy, bus_grant_n, data_phase_done
);
    initial {init_busy, bus_grant_n, data_phase_done} = 3'b010;
    // tenure runs from the start until the bank gives up the bus;
    // the phase ends a cycle late, the slow side of legal
    always @(posedge ref_clk) begin
        init_busy <= rst_n && !release_bus_r && (init_busy || init_start);
        bus_grant_n <= revoke;
        data_phase_done <= final_phase_r && !data_phase_done;
    end
endmodule

/* File: verification/pci_latency_aperture_cfg_tb.sv */
// bench for the bank: config reads and writes, then initiator slices
// assumes the arbiter model and the bound port checker
`timescale 1ns/10ps
`include "pci_latency_aperture_cfg_defines.vh"
module pci_latency_aperture_cfg_tb;
    reg         ref_clk = 1'b0, rst_n = 1'b0, cfg_wr = 1'b0, cfg_rd = 1'b0;
    reg         init_start = 1'b0, revoke = 1'b0;
    reg  [7:0]  cfg_addr = 8'h00;
    reg  [3:0]  cfg_be = 4'h0;
    reg  [31:0] cfg_wdata = 32'h0;
    reg  [5:0]  graphics_window_size_select = 6'h00;
    wire        init_busy, bus_grant_n, data_phase_done, cfg_rvalid_r;
    wire        slice_expired_r, final_phase_r, release_bus_r;
    wire [31:0] cfg_rdata_r, window_base_r;
    wire [7:0]  latency_count_r;
    integer     num_errors = 0, n_checks = 0, i, n;
    pci_latency_aperture_cfg u_pci_latency_aperture_cfg (.*);
    pci_arbiter_model u_pci_arbiter_model (.*);
    always #10 ref_clk = ~ref_clk;
    task chk(input [31:0] seen, input [31:0] exp);
        begin
            n_checks = n_checks + 1;
            if (seen !== exp) begin
                num_errors = num_errors + 1;
                $display("BAD %0t saw %h want %h", $time, seen, exp);
            end
        end
    endtask
    // one-cycle strobes, launched on the falling edge
    task wr(input [7:0] a, input [3:0] b, input [31:0] d);
        begin
            @(negedge ref_clk) {cfg_addr, cfg_be, cfg_wdata} = {a, b, d};
            cfg_wr = 1'b1;
            @(negedge ref_clk) cfg_wr = 1'b0;
        end
    endtask
    task rd(input [7:0] a, input [31:0] e);
        begin
            @(negedge ref_clk) cfg_addr = a;
            cfg_rd = 1'b1;
            @(negedge ref_clk) cfg_rd = 1'b0;
            chk({31'h0, cfg_rvalid_r}, 32'h1);
            chk(cfg_rdata_r, e);
        end
    endtask
    task finish_test;
        begin
            if (num_errors == 0 && n_checks > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask
    initial begin
        #100000 num_errors = num_errors + 1;
        finish_test;
    end
    initial begin
        repeat (3) @(negedge ref_clk);
        rst_n = 1'b1;
        rd(`LAT_TIMER_OFS, 32'h0);
        wr(`LAT_TIMER_OFS, 4'hF, 32'hFFFFFFFF);
        rd(`HDR_TYPE_OFS, 32'h0000FF00);
        rd(8'h20, 32'h0);
        rd(`WIN_BASE_OFS, 32'h8);
        // every window size; ones written before read-back
        for (i = 0; i < 7; i = i + 1) begin
            graphics_window_size_select = 6'h3F << i;
            wr(`WIN_BASE_OFS, 4'hF, 32'hFFFFFFFF);
            rd(`WIN_BASE_OFS,
               {4'hF, graphics_window_size_select, 22'h8});
            chk(window_base_r,
                {4'hF, graphics_window_size_select, 22'h8});
        end
        // low timer bits set, so only bits 7:3 count
        wr(`LAT_TIMER_OFS, 4'h2, 32'h00000F00);
        revoke = 1'b1;
        @(negedge ref_clk) init_start = 1'b1;
        @(negedge ref_clk) init_start = 1'b0;
        for (n = 0; slice_expired_r !== 1'b1 && n < 300; n = n + 1)
            @(negedge ref_clk);
        chk(n, 32'd8);
        chk({24'h0, latency_count_r}, 32'h0);
        for (n = 0; release_bus_r !== 1'b1 && n < 50; n = n + 1)
            @(negedge ref_clk);
        chk({31'h0, release_bus_r}, 32'h1);
        wr(`LAT_TIMER_OFS, 4'h2, 32'h0);
        @(negedge ref_clk) init_start = 1'b1;
        @(negedge ref_clk) init_start = 1'b0;
        repeat (40) @(negedge ref_clk);
        chk({30'h0, slice_expired_r, final_phase_r}, 32'h0);
        // reset in mid-run: timer back to zero, base back to its default
        wr(`LAT_TIMER_OFS, 4'h2, 32'h00000800);
        @(negedge ref_clk) rst_n = 1'b0;
        @(negedge ref_clk) rst_n = 1'b1;
        rd(`LAT_TIMER_OFS, 32'h0);
        chk(window_base_r, 32'h8);
        finish_test;
    end
endmodule
bind pci_latency_aperture_cfg cfg_bank_asserts u_cfg_bank_asserts (.*);
